// ===== irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  // printed offsets are not all multiples of four: they are register indices
  localparam logic [7:0] PIN_EDGE_SELECT_IDX = 8'hbf;
  localparam logic [7:0] IRQ_FLAG_REG_IDX = 8'hc8;
  localparam logic [7:0] IRQ_ENABLE_REG_IDX = 8'hc9;
  localparam logic [7:0] STACK_AND_GLOBAL_ENABLE_IDX = 8'hdf;
  // save buffer registers, register index as well
  localparam logic [7:0] SAVE_WORK_IDX = 8'he0;
  localparam logic [7:0] SAVE_STATUS_IDX = 8'he1;
  localparam int APB_ADDR_W = 10;
  // field positions
  localparam int PIN_BIT = 0;
  localparam int TIMER_A_BIT = 4;
  localparam int TIMER_B_BIT = 5;
  localparam int GLOBAL_ON_BIT = 7;
  localparam int EDGE_LO_BIT = 3;
  localparam logic [7:0] SRC_MASK = 8'h31;
  // status bits excluded from save and restore (timeout bit 3, power-down bit 2)
  localparam logic [7:0] STATUS_SAVE_MASK = 8'hf3;
  // reset values
  localparam logic [1:0] EDGE_SELECT_RESET = 2'h2;
  localparam logic [1:0] STACK_PTR_RESET = 2'h3;
  localparam logic [11:0] IRQ_VECTOR = 12'h008;
  localparam int PC_W = 12;

  typedef enum logic [1:0] {
    EDGE_RESERVED = 2'b00,
    EDGE_RISING = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SERVICE = 2'b01
  } irq_state_e;

  // core sequencer hand-off
  typedef struct packed {
    logic return_from_irq;
    logic save_req;
    logic restore_req;
    logic [7:0] work_register;
    logic [7:0] program_status_flags;
  } core_req_s;
endpackage

// ===== pin_edge_detect.sv
module pin_edge_detect (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pin and selection
  input wire logic pin_i,
  input wire irq_ctrl_pkg::edge_sel_e sel_i,
  // trigger pulse
  output logic trig_o
);
  import irq_ctrl_pkg::*;

  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic last_reg, last_next;
  logic trig_next;

  // two-stage synchroniser, then edge compare on the second stage only
  always_comb begin
    sync1_next = pin_i;
    sync2_next = sync1_reg;
    last_next = sync2_reg;
    unique case (sel_i)
      EDGE_RISING: trig_next = sync2_reg & ~last_reg;
      EDGE_FALLING: trig_next = ~sync2_reg & last_reg;
      EDGE_BOTH: trig_next = sync2_reg ^ last_reg;
      EDGE_RESERVED: trig_next = 1'b0;
    endcase
  end

  // registers; pin assumed idle high at reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      last_reg <= 1'b1;
      trig_o <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      last_reg <= last_next;
      trig_o <= trig_next;
    end
  end
endmodule // pin_edge_detect

// ===== three_source_interrupt_ctrl.sv
// Summary of operation
// - entering service clears the global enable bit.
// - completion of return-from-interrupt sets the global enable bit again.
// - accepting a request pushes one stack level and points the core at vector 8.
// - the enable register holds pin enable at bit 0, timer a at bit 4, timer b at bit 5, all zero at reset.
// - each flag is set by its event and stays set until software clears it.
// - the flag register holds pin flag at bit 0, timer a at bit 4, timer b at bit 5, read/write, zero at reset.
// - global enable is bit 7 of the stack register, zero at reset, and gates every service.
// - the pin flag sets on the selected trigger whatever its enable bit.
// - the pin source vectors only when its enable bit and flag are both one.
// - a two-bit edge field at bits 4:3 picks rising, falling or both edges and resets to falling.
// - timer a overflow sets its flag whatever its enable bit.
// - timer a vectors only when its enable bit is one.
// - save and restore move work register and status flags through one buffer, less timeout and power-down bits.
// - a pin trigger wakes the device from power-down into normal mode.
// - timer b overflow sets its flag whatever its enable bit and vectors only when enabled.
module three_source_interrupt_ctrl (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [irq_ctrl_pkg::APB_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // event sources
  input wire logic EXTERNAL_PIN_IRQ_I,
  input wire logic TIMER_A_OVF_I,
  input wire logic TIMER_B_OVF_I,
  // core sequencer
  input wire logic IRQ_ACCEPT_I,
  input wire irq_ctrl_pkg::core_req_s CORE_REQ_I,
  input wire logic POWERDOWN_I,
  output logic IRQ_REQ_O,
  output logic VECTOR_LOAD_O,
  output logic [irq_ctrl_pkg::PC_W-1:0] VECTOR_ADDR_O,
  output logic STACK_PUSH_O,
  output logic [1:0] STACK_POINTER_O,
  output logic [7:0] RESTORE_WORK_O,
  output logic [7:0] RESTORE_STATUS_O,
  output logic WAKEUP_O
);
  import irq_ctrl_pkg::*;

  // index decode from a byte address; shared by read and write paths
  function automatic logic [7:0] reg_index(input logic [APB_ADDR_W-1:0] a);
    reg_index = a[APB_ADDR_W-1:2];
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == PIN_EDGE_SELECT_IDX) || (idx == IRQ_FLAG_REG_IDX) || (idx == IRQ_ENABLE_REG_IDX)
      || (idx == STACK_AND_GLOBAL_ENABLE_IDX) || (idx == SAVE_WORK_IDX) || (idx == SAVE_STATUS_IDX);
  endfunction

  logic pin_trig;
  logic ta_last_reg;
  logic tb_last_reg;
  logic [7:0] flag_reg, flag_next;
  logic [7:0] enable_reg, enable_next;
  logic [1:0] edge_reg, edge_next;
  logic global_irq_on_reg, global_irq_on_next;
  logic [1:0] stack_pointer_bits_reg, stack_pointer_bits_next;
  logic [7:0] save_work_reg, save_work_next;
  logic [7:0] save_status_reg, save_status_next;
  irq_state_e state_reg, state_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic irq_req_next, vec_next, push_next, wake_next;
  logic [7:0] event_vec;
  logic [7:0] idx;
  logic wr, rd, acc;

  // pin edge detection with its own synchroniser
  pin_edge_detect u_pin_edge (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .pin_i(EXTERNAL_PIN_IRQ_I),
    .sel_i(edge_sel_e'(edge_reg)),
    .trig_o(pin_trig)
  );

  // timer overflows come from logic on this clock, so no synchroniser; a held level counts as one event
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ta_last_reg <= 1'b0;
      tb_last_reg <= 1'b0;
    end else begin
      ta_last_reg <= TIMER_A_OVF_I;
      tb_last_reg <= TIMER_B_OVF_I;
    end
  end

  // event vector laid out like the flag register
  always_comb begin
    event_vec = 8'h00;
    event_vec[PIN_BIT] = pin_trig;
    event_vec[TIMER_A_BIT] = TIMER_A_OVF_I & ~ta_last_reg;
    event_vec[TIMER_B_BIT] = TIMER_B_OVF_I & ~tb_last_reg;
  end

  assign idx = reg_index(PADDR_I);
  assign acc = PSEL_I & PENABLE_I;
  assign wr = acc & PWRITE_I & PSTRB_I[0] & mapped(idx);
  assign rd = acc & ~PWRITE_I;

  // register file, save buffer and service sequencing
  always_comb begin
    flag_next = flag_reg;
    enable_next = enable_reg;
    edge_next = edge_reg;
    global_irq_on_next = global_irq_on_reg;
    stack_pointer_bits_next = stack_pointer_bits_reg;
    save_work_next = save_work_reg;
    save_status_next = save_status_reg;
    state_next = state_reg;
    vec_next = 1'b0;
    push_next = 1'b0;
    if (wr) begin
      unique case (idx)
        PIN_EDGE_SELECT_IDX: edge_next = PWDATA_I[EDGE_LO_BIT +: 2];
        IRQ_FLAG_REG_IDX: flag_next = PWDATA_I[7:0] & SRC_MASK;
        IRQ_ENABLE_REG_IDX: enable_next = PWDATA_I[7:0] & SRC_MASK;
        STACK_AND_GLOBAL_ENABLE_IDX: begin
          global_irq_on_next = PWDATA_I[GLOBAL_ON_BIT];
          stack_pointer_bits_next = PWDATA_I[1:0];
        end
        SAVE_WORK_IDX: save_work_next = PWDATA_I[7:0];
        SAVE_STATUS_IDX: save_status_next = PWDATA_I[7:0] & STATUS_SAVE_MASK;
        default: ;
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    flag_next = flag_next | event_vec;
    // save instruction from the core sequencer
    if (CORE_REQ_I.save_req) begin
      save_work_next = CORE_REQ_I.work_register;
      save_status_next = CORE_REQ_I.program_status_flags & STATUS_SAVE_MASK;
    end
    unique case (state_reg)
      ST_RUN: begin
        if (IRQ_ACCEPT_I && IRQ_REQ_O && global_irq_on_reg) begin
          global_irq_on_next = 1'b0;
          stack_pointer_bits_next = stack_pointer_bits_reg - 2'h1;
          vec_next = 1'b1;
          push_next = 1'b1;
          state_next = ST_SERVICE;
        end
      end
      ST_SERVICE: begin
        if (CORE_REQ_I.return_from_irq) begin
          global_irq_on_next = 1'b1;
          stack_pointer_bits_next = stack_pointer_bits_reg + 2'h1;
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  // single request to the core; each source gated by its enable bit
  always_comb begin
    irq_req_next = global_irq_on_next && (state_next == ST_RUN)
      && ((flag_next & enable_next & SRC_MASK) != 8'h00);
    wake_next = POWERDOWN_I & event_vec[PIN_BIT];
  end

  // apb read data and answer: zero wait states, error on unmapped index
  always_comb begin
    prdata_next = 32'h0000_0000;
    pready_next = PSEL_I & ~PENABLE_I;
    pslverr_next = PSEL_I & ~PENABLE_I & ~mapped(idx);
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      unique case (idx)
        PIN_EDGE_SELECT_IDX: prdata_next[EDGE_LO_BIT +: 2] = edge_reg;
        IRQ_FLAG_REG_IDX: prdata_next[7:0] = flag_reg;
        IRQ_ENABLE_REG_IDX: prdata_next[7:0] = enable_reg;
        STACK_AND_GLOBAL_ENABLE_IDX: prdata_next[7:0] = {global_irq_on_reg, 5'h00, stack_pointer_bits_reg};
        SAVE_WORK_IDX: prdata_next[7:0] = save_work_reg;
        SAVE_STATUS_IDX: prdata_next[7:0] = save_status_reg;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flag_reg <= 8'h00;
      enable_reg <= 8'h00;
      edge_reg <= EDGE_SELECT_RESET;
      global_irq_on_reg <= 1'b0;
      stack_pointer_bits_reg <= STACK_PTR_RESET;
      save_work_reg <= 8'h00;
      save_status_reg <= 8'h00;
      state_reg <= ST_RUN;
      PRDATA_O <= 32'h0000_0000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      IRQ_REQ_O <= 1'b0;
      VECTOR_LOAD_O <= 1'b0;
      VECTOR_ADDR_O <= IRQ_VECTOR;
      STACK_PUSH_O <= 1'b0;
      STACK_POINTER_O <= STACK_PTR_RESET;
      RESTORE_WORK_O <= 8'h00;
      RESTORE_STATUS_O <= 8'h00;
      WAKEUP_O <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      enable_reg <= enable_next;
      edge_reg <= edge_next;
      global_irq_on_reg <= global_irq_on_next;
      stack_pointer_bits_reg <= stack_pointer_bits_next;
      save_work_reg <= save_work_next;
      save_status_reg <= save_status_next;
      state_reg <= state_next;
      PRDATA_O <= prdata_next;
      PREADY_O <= pready_next;
      PSLVERR_O <= pslverr_next;
      IRQ_REQ_O <= irq_req_next;
      VECTOR_LOAD_O <= vec_next;
      VECTOR_ADDR_O <= IRQ_VECTOR;
      STACK_PUSH_O <= push_next;
      STACK_POINTER_O <= stack_pointer_bits_next;
      RESTORE_WORK_O <= save_work_next;
      RESTORE_STATUS_O <= save_status_next;
      WAKEUP_O <= wake_next;
    end
  end

  logic unused_rd;
  assign unused_rd = rd;
endmodule // three_source_interrupt_ctrl

// ===== three_source_interrupt_ctrl_assertions.sv
module irq_ctrl_checker (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // apb handshake
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  // core side
  input wire logic IRQ_REQ_O,
  input wire logic IRQ_ACCEPT_I,
  input wire logic POWERDOWN_I,
  input wire logic VECTOR_LOAD_O,
  input wire logic [11:0] VECTOR_ADDR_O,
  input wire logic STACK_PUSH_O,
  input wire logic [1:0] STACK_POINTER_O,
  input wire logic [7:0] RESTORE_STATUS_O,
  input wire logic WAKEUP_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  // vectoring, stack, global enable, save mask and wakeup handling
  chk_accept_loads_vector: assert property (IRQ_REQ_O && IRQ_ACCEPT_I |=> VECTOR_LOAD_O)
    else $error("accepted request did not load the vector");
  chk_vector_addr_eight: assert property (VECTOR_LOAD_O |-> VECTOR_ADDR_O == 12'h008)
    else $error("vector address wrong at load");
  chk_push_with_load: assert property (VECTOR_LOAD_O == STACK_PUSH_O)
    else $error("stack push not paired with vector load");
  chk_stack_one_level: assert property (STACK_PUSH_O |-> STACK_POINTER_O == $past(STACK_POINTER_O) - 2'h1)
    else $error("stack pointer did not move one level");
  chk_req_blocked_service: assert property (VECTOR_LOAD_O |-> !IRQ_REQ_O ##1 !VECTOR_LOAD_O)
    else $error("request still raised after entering service");
  chk_status_mask_kept: assert property (RESTORE_STATUS_O[3:2] == 2'h0)
    else $error("timeout or power-down bit saved");
  chk_wake_in_powerdown: assert property (WAKEUP_O |-> POWERDOWN_I || $past(POWERDOWN_I))
    else $error("wakeup outside power-down");
  // apb answer timing
  chk_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
    else $error("apb answer not one cycle after setup");
endmodule // irq_ctrl_checker

// ===== core_model.sv
module core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // request and pacing
  input wire logic irq_req_i,
  input wire logic slow_i,
  // accept pulse
  output logic accept_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_reg;
  // takes a raised request at once, or after the request has been raised for three cycles when slow
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_reg <= 2'h0;
      accept_o <= 1'b0;
    end else begin
      accept_o <= irq_req_i && !accept_o && (!slow_i || wait_reg == 2'h3);
      wait_reg <= irq_req_i ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule // core_model

// ===== three_source_interrupt_ctrl_tb.sv
module three_source_interrupt_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_ctrl_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pin = 1, ta = 0, tbv = 0, pd = 0, slow = 0, woke = 0;
  logic acc, pready, pslverr, irq_req, vload, spush, wake, e;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [11:0] vaddr;
  logic [1:0] sp;
  logic [7:0] rw, rs;
  core_req_s core = '0;
  int failures = 0, num_checks = 0, cycles = 0;
  three_source_interrupt_ctrl u_three_source_interrupt_ctrl (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EXTERNAL_PIN_IRQ_I(pin), .TIMER_A_OVF_I(ta), .TIMER_B_OVF_I(tbv),
    .IRQ_ACCEPT_I(acc), .CORE_REQ_I(core), .POWERDOWN_I(pd), .IRQ_REQ_O(irq_req), .VECTOR_LOAD_O(vload),
    .VECTOR_ADDR_O(vaddr), .STACK_PUSH_O(spush), .STACK_POINTER_O(sp), .RESTORE_WORK_O(rw),
    .RESTORE_STATUS_O(rs), .WAKEUP_O(wake));
  core_model u_core_model (.clk_i(clk), .reset_n_i(rst_n), .irq_req_i(irq_req), .slow_i(slow), .accept_o(acc));
  always #20 clk = ~clk;
  // cycle ceiling and wakeup catcher
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) woke <= 1'b1;
    if (cycles == 4000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer, idle cycle after
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    chk(q, {24'h0, x});
  endtask
  task automatic drive_pin(input logic v);
    pin <= v;
    repeat (6) @(posedge clk);
  endtask
  // waits for the vector load, then checks target and stack
  task automatic vec(input logic [1:0] spx);
    int n;
    n = 0;
    while (vload !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({vaddr, 1'b0, spush, sp}, {12'h008, 1'b0, 1'b1, spx});
    rd(STACK_AND_GLOBAL_ENABLE_IDX, {6'h0, spx});
  endtask
  task automatic ret();
    core.return_from_irq <= 1'b1;
    @(posedge clk);
    core.return_from_irq <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(PIN_EDGE_SELECT_IDX, 8'h10);
    rd(IRQ_FLAG_REG_IDX, 8'h00);
    rd(IRQ_ENABLE_REG_IDX, 8'h00);
    rd(STACK_AND_GLOBAL_ENABLE_IDX, 8'h03);
    apb(1'b0, 8'h00, 8'h00);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(IRQ_ENABLE_REG_IDX, 8'hff);
    rd(IRQ_ENABLE_REG_IDX, 8'h31);
    wr(IRQ_ENABLE_REG_IDX, 8'h00);
    wr(STACK_AND_GLOBAL_ENABLE_IDX, 8'h83);
    // all three events with enables off
    {ta, tbv} <= 2'h3;
    drive_pin(1'b0);
    {ta, tbv} <= 2'h0;
    rd(IRQ_FLAG_REG_IDX, 8'h31);
    chk(irq_req, 1'b0);
    wr(IRQ_FLAG_REG_IDX, 8'h00);
    rd(IRQ_FLAG_REG_IDX, 8'h00);
    // every edge code against a rise then a fall
    for (int k = 0; k < 4; k++) begin
      wr(PIN_EDGE_SELECT_IDX, 8'(k << EDGE_LO_BIT));
      drive_pin(1'b1);
      rd(IRQ_FLAG_REG_IDX, {7'h0, k[0]});
      wr(IRQ_FLAG_REG_IDX, 8'h00);
      drive_pin(1'b0);
      rd(IRQ_FLAG_REG_IDX, {7'h0, k[1]});
      wr(IRQ_FLAG_REG_IDX, 8'h00);
    end
    // timer a service and return
    wr(IRQ_ENABLE_REG_IDX, 8'h10);
    ta <= 1'b1;
    vec(2'h2);
    ta <= 1'b0;
    rd(IRQ_FLAG_REG_IDX, 8'h10);
    wr(IRQ_FLAG_REG_IDX, 8'h00);
    ret();
    rd(STACK_AND_GLOBAL_ENABLE_IDX, 8'h83);
    // pin source held off by global enable, slow core
    wr(STACK_AND_GLOBAL_ENABLE_IDX, 8'h03);
    wr(IRQ_ENABLE_REG_IDX, 8'h01);
    slow <= 1'b1;
    drive_pin(1'b1);
    chk(irq_req, 1'b0);
    wr(STACK_AND_GLOBAL_ENABLE_IDX, 8'h83);
    vec(2'h2);
    wr(IRQ_FLAG_REG_IDX, 8'h00);
    ret();
    // save buffer drops status bits 3:2
    core <= '{1'b0, 1'b1, 1'b0, 8'ha5, 8'hff};
    @(posedge clk);
    core <= '0;
    @(posedge clk);
    chk({rw, rs}, 16'ha5f3);
    rd(SAVE_STATUS_IDX, 8'hf3);
    // pin trigger in power-down
    wr(IRQ_ENABLE_REG_IDX, 8'h00);
    pd <= 1'b1;
    drive_pin(1'b0);
    pd <= 1'b0;
    chk(woke, 1'b1);
    finish_test();
  end
endmodule // three_source_interrupt_ctrl_tb
bind three_source_interrupt_ctrl irq_ctrl_checker u_irq_ctrl_checker (.*);
